//--- rtl/cdb_top.sv
// Purpose: breakpoint triggers, trace port and debug serial access
// Assumes: core signals on ref_clk_i; serial pins are asynchronous
// Notes: supervisor access is an AXI access with prot[0] set
// What this block does
// - nine 32-bit breakpoint registers: address, data, four pc, masks
// - registers reachable from serial channel and supervisor bus access
// - triggers combine address, data, pc; one or two levels
// - fired trigger halts the core or raises a debug interrupt
// - critical interrupts still pass while a debug interrupt runs
// - drive 4-bit status bus and 4-bit debug data bus
// - status and branch targets with trace clock each cycle
// - all-status output is the AND of the four status bits
// - status bus reads 1111 while the core is halted
// - trace buses and trace clock exist only on the full package
// - serial channel and all-status output exist on every package
`timescale 1ns/1ns
`default_nettype none
module cdb_top
  import cdb_pkg::*;
#(
  parameter bit FULL_TRACE = 1'b1,
  parameter int IRQ_LVLS = 7
) (
  input wire logic ref_clk_i, // core clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire cdb_obs_t obs_i, // core bus and pc observation
  input wire cdb_trace_t trace_i, // core execution status and targets
  input wire logic core_halted_i, // core is halted
  input wire logic emu_mode_i, // core is in debug interrupt handler
  input wire logic [IRQ_LVLS-1:0] irq_pend_i, // pending irq by level
  output logic [IRQ_LVLS-1:0] irq_allow_o, // levels the core may take
  output logic halt_req_o, // one-cycle halt request
  output logic dbg_irq_o, // one-cycle debug interrupt request
  input wire logic debug_serial_clock, // serial clock from tool
  input wire logic debug_serial_in, // serial data from tool
  output logic debug_serial_out, // serial data to tool
  output logic [3:0] processor_status_bus, // trace status
  output logic [3:0] debug_data_bus, // trace data nibbles
  output logic trace_clock_out, // trace clock
  output logic all_status_halted, // AND of status bits
  output logic irq_o // block interrupt
);
  initial begin
    if (IRQ_LVLS < 1 || IRQ_LVLS > 8) $error("IRQ_LVLS out of range");
  end

  logic [31:0] bp_q [CDB_NBP];
  logic [CDB_CTL_W-1:0] ctrl_q;
  logic [2:0] crit_q;
  logic [CDB_INT_W-1:0] int_stat_q;
  logic [CDB_INT_W-1:0] int_en_q;
  cdb_trig_t tr_q;
  cdb_trig_t tr_d;
  cdb_ser_req_t ser_req;
  logic halted_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  function automatic logic [31:0] rd_word(input logic [3:0] idx,
      input logic [31:0] bp [CDB_NBP], input logic [CDB_CTL_W-1:0] ctl,
      input cdb_trig_t tr, input logic hlt, input logic [2:0] crit);
    logic [31:0] w;
    w = '0;
    if (idx <= CDB_IDX_PC_MASK) w = bp[idx];
    else if (idx == CDB_IDX_CTRL) w = 32'(ctl);
    else if (idx == CDB_IDX_STAT) w = {28'h000_0000, hlt, tr};
    else if (idx == CDB_IDX_CRIT) w = 32'(crit);
    return w;
  endfunction : rd_word

  // serial channel, present on every package
  wire [31:0] ser_rdata = ser_req.we ? ser_req.wdata :
    rd_word(ser_req.idx, bp_q, ctrl_q, tr_q, halted_q, crit_q);
  cdb_serial u_serial (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ser_clk_i(debug_serial_clock),
    .ser_in_i(debug_serial_in),
    .rdata_i(ser_rdata),
    .req_o(ser_req),
    .ser_out_o(debug_serial_out)
  );
  wire ser_wr = ser_req.valid & ser_req.we;

  // bus slave decode
  wire aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~ser_wr;
  wire ar_go = s_axi_arvalid & ~s_axi_rvalid;
  wire w_sup = s_axi_awprot[0];
  wire r_sup = s_axi_arprot[0];
  wire [3:0] w_idx = s_axi_awaddr[5:2];
  wire [3:0] r_idx = s_axi_araddr[5:2];
  wire w_int = (s_axi_awaddr == CDB_OFF_INT_EN) |
               (s_axi_awaddr == CDB_OFF_INT_CLR);
  wire w_map = (s_axi_awaddr[1:0] == 2'b00) &
               ((s_axi_awaddr <= CDB_OFF_CRIT) | w_int);
  wire w_cfg = aw_go & w_sup & (s_axi_awaddr <= CDB_OFF_CRIT) &
               (s_axi_awaddr[1:0] == 2'b00) & (s_axi_awaddr != CDB_OFF_STAT);
  wire r_map = (s_axi_araddr[1:0] == 2'b00) &
               (s_axi_araddr <= CDB_OFF_INT_EN);
  wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] axi_cur =
    rd_word(w_idx, bp_q, ctrl_q, tr_q, halted_q, crit_q);
  wire [31:0] axi_wval = (axi_cur & ~strb_mask) | (s_axi_wdata & strb_mask);
  wire wr_en = ser_wr | w_cfg;
  wire [3:0] wr_idx = ser_wr ? ser_req.idx : w_idx;
  wire [31:0] wr_val = ser_wr ? ser_req.wdata : axi_wval;
  wire [31:0] r_word =
    (s_axi_araddr == CDB_OFF_INT_STAT) ? 32'(int_stat_q) :
    (s_axi_araddr == CDB_OFF_INT_EN) ? 32'(int_en_q) :
    rd_word(r_idx, bp_q, ctrl_q, tr_q, halted_q, crit_q);

  // breakpoint and control registers; serial wins a same-cycle write
  genvar gi;
  for (gi = 0; gi < CDB_NBP; gi++) begin : g_bp
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        bp_q[gi] <= (gi == 1 || gi == 3 || gi == 8) ?
                    CDB_RST_MASK : CDB_RST_ZERO;
      end else if (wr_en && wr_idx == 4'(gi)) begin
        bp_q[gi] <= wr_val;
      end
    end
  end

  wire ctrl_wr = wr_en & (wr_idx == CDB_IDX_CTRL);
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= '0;
      crit_q <= CDB_RST_CRIT;
    end else begin
      if (ctrl_wr) ctrl_q <= wr_val[CDB_CTL_W-1:0];
      if (wr_en && wr_idx == CDB_IDX_CRIT) crit_q <= wr_val[2:0];
    end
  end

  // match logic
  wire a_hit = obs_i.addr_valid &
    (((obs_i.addr ^ bp_q[0]) & bp_q[1]) == 32'h0000_0000);
  wire d_hit = obs_i.data_valid &
    (((obs_i.data ^ bp_q[2]) & bp_q[3]) == 32'h0000_0000);
  logic [CDB_NPC-1:0] pc_hits;
  for (gi = 0; gi < CDB_NPC; gi++) begin : g_pc
    assign pc_hits[gi] = obs_i.pc_valid &
      (((obs_i.pc ^ bp_q[4+gi]) & bp_q[8]) == 32'h0000_0000);
  end
  wire p_hit = |pc_hits;
  wire ea = ctrl_q[CDB_CTL_EA];
  wire ed = ctrl_q[CDB_CTL_ED];
  wire ep = ctrl_q[CDB_CTL_EP];
  wire ad_any = ea | ed;
  wire ad_cond = ad_any & (~ea | a_hit) & (~ed | d_hit);
  wire one_cond = (ad_any | ep) & (~ea | a_hit) & (~ed | d_hit) &
                  (~ep | p_hit);
  wire two = ctrl_q[CDB_CTL_TWO];
  wire armed = ctrl_q[CDB_CTL_ARM];
  wire lvl1_hit = (tr_q == CDB_TR_L1) & armed & two & ep & p_hit;
  wire fire = armed & ~ctrl_wr &
    (((tr_q == CDB_TR_L1) & ~two & one_cond) |
     ((tr_q == CDB_TR_L2) & ad_cond));

  always_comb begin
    tr_d = tr_q;
    case (tr_q)
      CDB_TR_L1: begin
        if (fire) tr_d = CDB_TR_DONE;
        else if (lvl1_hit) tr_d = CDB_TR_L2;
      end
      CDB_TR_L2: begin
        if (fire) tr_d = CDB_TR_DONE;
      end
      CDB_TR_DONE: tr_d = CDB_TR_DONE;
      default: tr_d = CDB_TR_L1;
    endcase
    if (ctrl_wr) tr_d = CDB_TR_L1;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tr_q <= CDB_TR_L1;
      halt_req_o <= 1'b0;
      dbg_irq_o <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      tr_q <= tr_d;
      halt_req_o <= fire & ctrl_q[CDB_CTL_HALT];
      dbg_irq_o <= fire & ~ctrl_q[CDB_CTL_HALT];
      halted_q <= core_halted_i;
    end
  end

  // critical levels stay open inside the debug interrupt handler
  logic [IRQ_LVLS-1:0] crit_open;
  for (gi = 0; gi < IRQ_LVLS; gi++) begin : g_irq
    assign crit_open[gi] = (3'(gi) >= crit_q);
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) irq_allow_o <= '0;
    else irq_allow_o <= emu_mode_i ? (irq_pend_i & crit_open) : irq_pend_i;
  end

  // interrupt status: set wins over clear
  wire [CDB_INT_W-1:0] ev = {ser_req.valid, core_halted_i & ~halted_q,
                             lvl1_hit, fire};
  wire clr_go = aw_go & w_sup & (s_axi_awaddr == CDB_OFF_INT_CLR);
  wire [CDB_INT_W-1:0] clr = clr_go ? s_axi_wdata[CDB_INT_W-1:0] : '0;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_stat_q <= '0;
      int_en_q <= '0;
      irq_o <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~clr) | ev;
      if (aw_go && w_sup && s_axi_awaddr == CDB_OFF_INT_EN)
        int_en_q <= s_axi_wdata[CDB_INT_W-1:0];
      irq_o <= |(((int_stat_q & ~clr) | ev) & int_en_q);
    end
  end

  // bus answers, one cycle after the request is taken
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CDB_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      rdata_q <= '0;
      rresp_q <= CDB_RESP_OKAY;
    end else begin
      if (aw_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (w_sup & w_map & (s_axi_awaddr != CDB_OFF_STAT)) ?
                       CDB_RESP_OKAY : CDB_RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        rdata_q <= (r_sup & r_map) ? r_word : 32'h0000_0000;
        rresp_q <= (r_sup & r_map) ? CDB_RESP_OKAY : CDB_RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_awready = aw_go;
  assign s_axi_wready = aw_go;
  assign s_axi_arready = ar_go;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // trace port: status each cycle, targets as eight nibbles low first
  logic [31:0] nib_q;
  logic [3:0] nib_cnt_q;
  logic [3:0] pst_q;
  logic [3:0] dd_q;
  logic tclk_q;
  logic all_q;
  wire nib_busy = (nib_cnt_q != 4'h0);
  wire [3:0] pst_d = core_halted_i ? CDB_PST_HALTED : trace_i.status;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nib_q <= '0;
      nib_cnt_q <= '0;
      pst_q <= '0;
      dd_q <= '0;
      tclk_q <= 1'b0;
      all_q <= 1'b0;
    end else begin
      all_q <= &pst_d;
      if (FULL_TRACE) begin
        pst_q <= pst_d;
        tclk_q <= ~tclk_q;
        if (nib_busy) begin
          dd_q <= nib_q[3:0];
          nib_q <= {4'h0, nib_q[31:4]};
          nib_cnt_q <= nib_cnt_q - 4'h1;
        end else if (trace_i.tgt_valid) begin
          dd_q <= trace_i.tgt[3:0];
          nib_q <= {4'h0, trace_i.tgt[31:4]};
          nib_cnt_q <= 4'(CDB_NIB - 1);
        end else begin
          dd_q <= 4'h0;
        end
      end
    end
  end
  assign processor_status_bus = pst_q;
  assign debug_data_bus = dd_q;
  assign trace_clock_out = tclk_q;
  assign all_status_halted = all_q;
endmodule : cdb_top
`default_nettype wire

//--- rtl/cdb_pkg.sv
// Purpose: shared constants and carriers of the core debug block
// Assumes: 32-bit AXI4-Lite register access, one 250 MHz clock
// Notes: serial frame is 40 bits, msb first, both directions
package cdb_pkg;
  localparam int CDB_DW = 32;
  localparam int CDB_AW = 8;
  localparam int CDB_NBP = 9;
  localparam int CDB_NPC = 4;
  localparam int CDB_IDXW = 4;
  // register byte offsets
  localparam logic [7:0] CDB_OFF_ADDR = 8'h00;
  localparam logic [7:0] CDB_OFF_ADDR_MASK = 8'h04;
  localparam logic [7:0] CDB_OFF_DATA = 8'h08;
  localparam logic [7:0] CDB_OFF_DATA_MASK = 8'h0C;
  localparam logic [7:0] CDB_OFF_PC0 = 8'h10;
  localparam logic [7:0] CDB_OFF_PC_MASK = 8'h20;
  localparam logic [7:0] CDB_OFF_CTRL = 8'h24;
  localparam logic [7:0] CDB_OFF_STAT = 8'h28;
  localparam logic [7:0] CDB_OFF_CRIT = 8'h2C;
  localparam logic [7:0] CDB_OFF_INT_STAT = 8'h30;
  localparam logic [7:0] CDB_OFF_INT_EN = 8'h34;
  localparam logic [7:0] CDB_OFF_INT_CLR = 8'h38;
  // serial register indices
  localparam logic [3:0] CDB_IDX_PC_MASK = 4'h8;
  localparam logic [3:0] CDB_IDX_CTRL = 4'h9;
  localparam logic [3:0] CDB_IDX_STAT = 4'hA;
  localparam logic [3:0] CDB_IDX_CRIT = 4'hB;
  // control field positions
  localparam int CDB_CTL_EA = 0;
  localparam int CDB_CTL_ED = 1;
  localparam int CDB_CTL_EP = 2;
  localparam int CDB_CTL_TWO = 3;
  localparam int CDB_CTL_HALT = 4;
  localparam int CDB_CTL_ARM = 5;
  localparam int CDB_CTL_W = 6;
  // interrupt status bits
  localparam int CDB_INT_FIRE = 0;
  localparam int CDB_INT_LVL1 = 1;
  localparam int CDB_INT_HALT = 2;
  localparam int CDB_INT_SER = 3;
  localparam int CDB_INT_W = 4;
  // reset values
  localparam logic [31:0] CDB_RST_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] CDB_RST_ZERO = 32'h0000_0000;
  localparam logic [2:0] CDB_RST_CRIT = 3'h7;
  localparam logic [3:0] CDB_PST_HALTED = 4'hF;
  // serial frame
  localparam int CDB_FRAME = 40;
  localparam logic [7:0] CDB_SER_OK = 8'hA5;
  localparam int CDB_NIB = 8;
  // axi answers
  localparam logic [1:0] CDB_RESP_OKAY = 2'b00;
  localparam logic [1:0] CDB_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [31:0] addr;
    logic addr_valid;
    logic [31:0] data;
    logic data_valid;
    logic [31:0] pc;
    logic pc_valid;
  } cdb_obs_t;

  typedef struct packed {
    logic [3:0] status;
    logic tgt_valid;
    logic [31:0] tgt;
  } cdb_trace_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [3:0] idx;
    logic [31:0] wdata;
  } cdb_ser_req_t;

  typedef enum logic [2:0] {
    CDB_TR_L1 = 3'b001,
    CDB_TR_L2 = 3'b010,
    CDB_TR_DONE = 3'b100
  } cdb_trig_t;
endpackage : cdb_pkg

//--- rtl/cdb_serial.sv
// Purpose: three-wire debug serial channel, tool drives the clock
// Assumes: serial clock far slower than ref_clk_i, sampled as a level
// Notes: bits taken on clock rise, answer bits change on clock fall
`timescale 1ns/1ns
`default_nettype none
module cdb_serial
  import cdb_pkg::*;
(
  input wire logic ref_clk_i, // core clock
  input wire logic nrst_i, // async reset, active low
  input wire logic ser_clk_i, // debug_serial_clock pin
  input wire logic ser_in_i, // serial input pin
  input wire logic [31:0] rdata_i, // read word for the request index
  output cdb_ser_req_t req_o, // one-cycle register request
  output logic ser_out_o // debug_serial_out pin
);
  logic [1:0] clk_sq;
  logic [1:0] din_sq;
  logic clk_prev_q;
  logic [39:0] in_q;
  logic [39:0] out_q;
  logic [5:0] cnt_q;
  logic ser_out_q;
  wire rise = clk_sq[1] & ~clk_prev_q;
  wire fall = ~clk_sq[1] & clk_prev_q;
  wire last = (cnt_q == 6'(CDB_FRAME - 1));
  wire [39:0] frame = {in_q[38:0], din_sq[1]};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_sq <= 2'b00;
      din_sq <= 2'b00;
      clk_prev_q <= 1'b0;
    end else begin
      clk_sq <= {clk_sq[0], ser_clk_i};
      din_sq <= {din_sq[0], ser_in_i};
      clk_prev_q <= clk_sq[1];
    end
  end

  // the tool clocks one bit per serial clock
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_q <= '0;
      cnt_q <= '0;
      req_o <= '0;
    end else begin
      req_o.valid <= rise & last;
      if (rise) begin
        in_q <= frame;
        cnt_q <= last ? 6'd0 : cnt_q + 6'd1;
        if (last) begin
          req_o.we <= frame[39];
          req_o.idx <= frame[35:32];
          req_o.wdata <= frame[31:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_q <= '0;
      ser_out_q <= 1'b0;
    end else if (req_o.valid) begin
      out_q <= {CDB_SER_OK, rdata_i};
    end else if (fall) begin
      ser_out_q <= out_q[39];
      out_q <= {out_q[38:0], 1'b0};
    end
  end

  assign ser_out_o = ser_out_q;
endmodule : cdb_serial
`default_nettype wire

//--- testbench/cdb_top_properties.sv
// Purpose: port assertions for the core debug block
// Assumes: full trace package, one clock domain
// Notes: bound to cdb_top from tb_top
`timescale 1ns/1ns
`default_nettype none
module cdb_props
  import cdb_pkg::*;
#(
  parameter int IRQ_LVLS = 7
) (
  input wire logic ref_clk_i, // clock
  input wire logic nrst_i, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [2:0] s_axi_arprot, // ar prot
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire cdb_trace_t trace_i, // trace in
  input wire logic core_halted_i, // halted
  input wire logic [IRQ_LVLS-1:0] irq_pend_i, // pending
  input wire logic [IRQ_LVLS-1:0] irq_allow_o, // allowed
  input wire logic halt_req_o, // halt pulse
  input wire logic dbg_irq_o, // irq pulse
  input wire logic [3:0] processor_status_bus, // status
  input wire logic [3:0] debug_data_bus, // data
  input wire logic trace_clock_out, // trace clock
  input wire logic all_status_halted // and of status
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  // trace port and irq checks wait for the first three edges after reset
  assign up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) up_q <= 2'h0;
    else up_q <= up_d;
  end
  wire logic live = (up_q == 2'h3);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  status_and_a: assert property (
    live |-> all_status_halted == &processor_status_bus)
    else $error("all-status differs from status AND");
  halted_ones_a: assert property (
    live && core_halted_i |=> processor_status_bus == CDB_PST_HALTED)
    else $error("status bus not all ones while halted");
  status_pass_a: assert property (
    live && !core_halted_i |=>
      processor_status_bus == $past(trace_i.status))
    else $error("status bus does not follow core status");
  tclk_toggle_a: assert property (
    live |=> trace_clock_out != $past(trace_clock_out))
    else $error("trace clock missed a toggle");
  tgt_nibble_a: assert property (
    live && trace_i.tgt_valid |=> debug_data_bus == $past(trace_i.tgt[3:0]))
    else $error("first target nibble wrong");
  resp_pulse_a: assert property (
    halt_req_o || dbg_irq_o |=> !(halt_req_o || dbg_irq_o))
    else $error("trigger response longer than one cycle");
  one_resp_a: assert property (!(halt_req_o && dbg_irq_o))
    else $error("halt and debug irq together");
  allow_sub_a: assert property (
    live |-> (irq_allow_o & ~$past(irq_pend_i)) == '0)
    else $error("irq allowed that is not pending");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  write_ans_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  user_read_a: assert property (
    s_axi_arvalid && s_axi_arready && !s_axi_arprot[0]
      |=> s_axi_rvalid && s_axi_rresp == CDB_RESP_SLVERR)
    else $error("user mode read not refused");
  halt_c: cover property (halt_req_o);
  dirq_c: cover property (dbg_irq_o);
  halted_c: cover property (core_halted_i && all_status_halted);
endmodule : cdb_props
`default_nettype wire

//--- testbench/cdb_tool_model.sv
// Purpose: external debug tool on the three-wire serial channel
// Assumes: tool owns the serial clock, idle low between frames
// Notes: frame task sends msb first and samples on each rise
`timescale 1ns/1ns
`default_nettype none
module cdb_tool (
  output logic debug_serial_clock, // serial clock to device
  output logic debug_serial_in, // serial data to device
  input wire logic debug_serial_out // serial data from device
);
  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b0;
  end
  // half sets the speed: 80 for the nominal rate, more for a slow tool
  task automatic frame(input logic [39:0] tx, input int half,
                       output logic [39:0] rx);
    for (int i = 39; i >= 0; i--) begin
      debug_serial_in = tx[i];
      #(half);
      debug_serial_clock = 1'b1;
      rx[i] = debug_serial_out;
      #(half);
      debug_serial_clock = 1'b0;
    end
    // a released line must not keep showing the last bit
    debug_serial_in = ~tx[0];
  endtask : frame
endmodule : cdb_tool
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the core debug block
// Assumes: full trace package, supervisor access via prot bit 0
// Notes: expectations come from a bench copy of the registers
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cdb_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0;
  logic [2:0] s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, halt_req_o, dbg_irq_o, irq_o, trace_clock_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  cdb_obs_t obs_i = '0;
  cdb_trace_t trace_i = '0;
  logic core_halted_i = 1'b0;
  logic emu_mode_i = 1'b0;
  logic [6:0] irq_pend_i = '0;
  logic [6:0] irq_allow_o;
  logic debug_serial_clock, debug_serial_in, debug_serial_out;
  logic all_status_halted;
  logic [3:0] processor_status_bus, debug_data_bus;
  int num_errors = 0;
  int checks = 0;
  int seed = 32'hcbf7_45f4;
  logic [31:0] exp_reg [12];
  logic [31:0] flip [4] = '{32'h0000_0100, 32'h0000_0055,
                            32'h8000_0000, 32'h0000_00ff};

  cdb_top #(.FULL_TRACE(1'b1), .IRQ_LVLS(7)) cdb_top_i (.*);
  cdb_tool cdb_tool_i (.*);

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // returns at the rising edge where f is high
  task automatic edge_when(ref logic f);
    int n = 0;
    @(negedge ref_clk_i);
    while (f !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 200) begin
      num_errors++;
      wrap_up();
    end
    @(posedge ref_clk_i);
  endtask : edge_when

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic p, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_awprot <= {2'h0, p};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    edge_when(s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    edge_when(s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic p,
                        output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arprot <= {2'h0, p};
    s_axi_arvalid <= 1'b1;
    edge_when(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    edge_when(s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, 1'b1, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, CDB_RESP_OKAY});
  endtask : rd_chk

  // present one observation, then count response pulses
  task automatic hit(input cdb_obs_t o, output int h, output int g);
    h = 0;
    g = 0;
    obs_i <= o;
    repeat (8) begin
      @(posedge ref_clk_i);
      obs_i <= '0;
      h += int'(halt_req_o === 1'b1);
      g += int'(dbg_irq_o === 1'b1);
    end
  endtask : hit

  initial begin
    logic [31:0] d, v, p;
    logic [1:0] r;
    logic [39:0] rx;
    logic [6:0] pn;
    int h, g;
    cdb_obs_t oa;
    for (int i = 0; i < 12; i++)
      exp_reg[i] = (i inside {1, 3, 8}) ? CDB_RST_MASK : '0;
    exp_reg[11] = {29'h0, CDB_RST_CRIT};
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int i = 0; i < 12; i++)
      if (i != 10) rd_chk(8'(i * 4), exp_reg[i]);
    $display("end reset values");
    for (int i = 0; i < 9; i++) begin
      exp_reg[i] = $random(seed);
      axi_wr(8'(i * 4), exp_reg[i], 1'b1, r);
    end
    for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), exp_reg[i]);
    axi_wr(CDB_OFF_ADDR, ~exp_reg[0], 1'b0, r);
    chk({30'h0, r}, {30'h0, CDB_RESP_SLVERR});
    rd_chk(CDB_OFF_ADDR, exp_reg[0]);
    axi_rd(8'h3c, 1'b1, d, r);
    chk(d, '0);
    chk({30'h0, r}, {30'h0, CDB_RESP_SLVERR});
    axi_rd(CDB_OFF_ADDR, 1'b0, d, r);
    chk({30'h0, r}, {30'h0, CDB_RESP_SLVERR});
    $display("end register access");
    v = $random(seed);
    cdb_tool_i.frame({4'h8, 4'h2, v}, 80, rx);
    exp_reg[2] = v;
    cdb_tool_i.frame({4'h0, 4'h5, 32'h0}, 80, rx);
    chk({24'h0, rx[39:32]}, {24'h0, CDB_SER_OK});
    chk(rx[31:0], v);
    cdb_tool_i.frame({4'h0, 4'h5, 32'h0}, 200, rx);
    chk(rx[31:0], exp_reg[5]);
    @(posedge ref_clk_i);
    rd_chk(CDB_OFF_DATA, v);
    $display("end serial channel");
    v = $random(seed);
    axi_wr(CDB_OFF_ADDR, v, 1'b1, r);
    axi_wr(CDB_OFF_ADDR_MASK, 32'hffff_ff00, 1'b1, r);
    foreach (flip[k]) begin
      axi_wr(CDB_OFF_CTRL, 32'h0000_0031, 1'b1, r);
      hit('{addr: v ^ flip[k], addr_valid: 1'b1, default: '0}, h, g);
      chk(32'(h), 32'((flip[k] & 32'hffff_ff00) == 0));
      chk(32'(g), '0);
    end
    oa = '{addr: v, addr_valid: 1'b1, default: '0};
    axi_wr(CDB_OFF_CTRL, 32'h0000_0021, 1'b1, r);
    hit(oa, h, g);
    chk(32'(h * 2 + g), 32'h0000_0001);
    $display("end single level");
    p = $random(seed);
    axi_wr(CDB_OFF_INT_CLR, 32'h0000_000f, 1'b1, r);
    axi_wr(CDB_OFF_INT_EN, 32'h0000_0001, 1'b1, r);
    axi_wr(CDB_OFF_PC0, p, 1'b1, r);
    axi_wr(CDB_OFF_PC_MASK, 32'hffff_ffff, 1'b1, r);
    axi_wr(CDB_OFF_CTRL, 32'h0000_002d, 1'b1, r);
    hit(oa, h, g);
    chk(32'(g), '0);
    hit('{pc: p, pc_valid: 1'b1, default: '0}, h, g);
    chk(32'(g), '0);
    hit(oa, h, g);
    chk(32'(g), 32'h0000_0001);
    rd_chk(CDB_OFF_INT_STAT, 32'h0000_0003);
    chk({31'h0, irq_o}, 32'h0000_0001);
    axi_wr(CDB_OFF_INT_EN, 32'h0000_0000, 1'b1, r);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    axi_wr(CDB_OFF_INT_EN, 32'h0000_0001, 1'b1, r);
    axi_wr(CDB_OFF_INT_CLR, 32'h0000_0001, 1'b1, r);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rd_chk(CDB_OFF_INT_STAT, 32'h0000_0002);
    $display("end two level");
    axi_wr(CDB_OFF_CRIT, 32'h0000_0003, 1'b1, r);
    emu_mode_i <= 1'b1;
    repeat (4) begin
      pn = 7'($random(seed));
      irq_pend_i <= pn;
      repeat (3) @(posedge ref_clk_i);
      chk({25'h0, irq_allow_o}, {25'h0, pn & 7'h78});
    end
    emu_mode_i <= 1'b0;
    core_halted_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk({27'h0, all_status_halted, processor_status_bus},
        {27'h0, 1'b1, CDB_PST_HALTED});
    core_halted_i <= 1'b0;
    repeat (16) begin
      trace_i.status <= 4'($random(seed));
      @(posedge ref_clk_i);
    end
    v = $random(seed);
    trace_i <= '{status: 4'h0, tgt_valid: 1'b1, tgt: v};
    @(posedge ref_clk_i);
    trace_i.tgt_valid <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(posedge ref_clk_i);
      chk({28'h0, debug_data_bus}, {28'h0, v[4 * n +: 4]});
    end
    $display("end trace port");
    wrap_up();
  end
endmodule : tb_top

bind cdb_top cdb_props #(.IRQ_LVLS(IRQ_LVLS)) cdb_props_i (.*);
`default_nettype wire
